// >>> verification/tb_top.sv
// testbench for the two-wire key store slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, reset, scan_done, scl, sda_drv, rx_stb, ack_n;
  logic sda_out, sda_oe_n, int_out, disp_wr_stb, sda_line;
  logic [38:0] scan_keys, ka, kb;
  logic [2:0] strap;
  logic [7:0] rx_byte, disp_wr_addr, disp_wr_data, dev_w, d;
  logic [7:0] exp_rd[$];
  logic [15:0] exp_wr[$];
  int n_mismatch, n_tests, cyc;
  // pull-up on the data line, wired-and of both parties
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  keyscan_i2c_slave u_keyscan_i2c_slave (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bits(strap), .scan_done(scan_done),
    .scan_keys(scan_keys), .int_out(int_out), .disp_wr_addr(disp_wr_addr), .disp_wr_data(disp_wr_data),
    .disp_wr_stb(disp_wr_stb));
  twowire_master_model u_twowire_master_model (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv), .rx_stb(rx_stb), .rx_byte(rx_byte));
  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] kbyte(input logic [38:0] k, input int i);
    logic [12:0] l;
    l = k[13 * (i / 2) +: 13];
    return (i % 2) ? {3'h0, l[12:8]} : l[7:0];
  endfunction
  // one scan cycle result, pulsed for one clock
  task automatic scan(input logic [38:0] k);
    @(posedge clk);
    #1 scan_done = 1'b1;
    scan_keys = k;
    @(posedge clk);
    #1 scan_done = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic int_chk(input logic e);
    repeat (3) @(posedge clk);
    #1 chk1("int_out", e, int_out);
  endtask
  task automatic wbyte(input logic [7:0] v);
    u_twowire_master_model.write_byte(v, ack_n);
    chk1("data_ack_n", 1'b0, ack_n);
  endtask
  task automatic open_write(input logic [7:0] cmd);
    u_twowire_master_model.start_cond();
    u_twowire_master_model.write_byte(dev_w, ack_n);
    chk1("addr_ack_n", 1'b0, ack_n);
    wbyte(cmd);
  endtask
  // full key read from the first location, one byte past the wrap
  task automatic read_keys(input logic [38:0] k);
    open_write(8'h40);
    u_twowire_master_model.start_cond();
    u_twowire_master_model.write_byte(dev_w | 8'h01, ack_n);
    chk1("addr_rd_ack_n", 1'b0, ack_n);
    for (int i = 0; i < 7; i++)
    begin
      exp_rd.push_back(i < 6 ? kbyte(k, i) : 8'h00);
      u_twowire_master_model.read_byte(i == 6);
    end
    u_twowire_master_model.stop_cond();
  endtask
  // ---------------------------------------------------------------
  // clock, timeout and result monitor
  // ---------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // oldest expected note is taken whenever a result appears
  always @(posedge clk)
  begin
    if (rx_stb === 1'b1)
      chk8("read_byte", exp_rd.size() ? exp_rd.pop_front() : 8'hxx, rx_byte);
    if (disp_wr_stb === 1'b1)
    begin
      chk8("disp_wr_addr", exp_wr.size() ? exp_wr[0][15:8] : 8'hxx, disp_wr_addr);
      chk8("disp_wr_data", exp_wr.size() ? exp_wr.pop_front() : 8'hxx, disp_wr_data);
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    scan_done = 1'b0;
    scan_keys = '0;
    void'($urandom(32'hd59e4022));
    strap = 3'($urandom);
    dev_w = {4'he, strap, 1'b0};
    ka = 39'({$urandom, $urandom});
    kb = 39'({$urandom, $urandom});
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk1("int_out_reset", 1'b1, int_out);
    // foreign address is refused and the rest of the frame ignored
    u_twowire_master_model.start_cond();
    u_twowire_master_model.write_byte(dev_w ^ 8'h02, ack_n);
    chk1("foreign_ack_n", 1'b1, ack_n);
    u_twowire_master_model.write_byte(8'h00, ack_n);
    chk1("ignored_ack_n", 1'b1, ack_n);
    u_twowire_master_model.stop_cond();
    // display burst across the wrap from the second-to-last location
    open_write(8'h0e);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      exp_wr.push_back({(8'h0e + 8'(i)) & 8'h0f, d});
      wbyte(d);
    end
    u_twowire_master_model.stop_cond();
    // two confirming scans before the flag rises
    scan('0);
    scan(ka);
    int_chk(1'b1);
    scan(ka);
    int_chk(1'b0);
    scan(kb);
    scan(kb);
    // writes into key locations are dropped
    open_write(8'h40);
    wbyte(8'hff);
    u_twowire_master_model.stop_cond();
    read_keys(ka | kb);
    int_chk(1'b1);
    // held key is not reported again until released
    scan(kb);
    scan(kb);
    int_chk(1'b1);
    scan('0);
    scan(kb);
    scan(kb);
    int_chk(1'b0);
    read_keys(kb);
    int_chk(1'b1);
    // active-high interrupt polarity
    open_write(8'ha3);
    u_twowire_master_model.stop_cond();
    int_chk(1'b0);
    scan('0);
    scan(ka);
    scan(ka);
    int_chk(1'b1);
    chk8("rd_notes_left", 8'h00, 8'(exp_rd.size()));
    chk8("wr_notes_left", 8'h00, 8'(exp_wr.size()));
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// >>> verification/twowire_master_model.sv
// two-wire bus master model driving the clock line directly and the data line open-drain
`timescale 1ns/1ns
`default_nettype none
module twowire_master_model
(
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  // ---------------------------------------------------------------
  // bus phases, eight clocks per bit phase except sixteen high in a start and nine low before a read acknowledge
  // ---------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // wait whole clocks, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start_cond();
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask
  // stop: data rises while clock is high, bus then idle
  task automatic stop_cond();
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b1;
    tick(8);
  endtask
  // data set mid-low and held through the high phase
  task automatic put_bit(input logic b);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask
  // release data and sample it mid-high
  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    b = sda_line;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic write_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack_n);
  endtask
  // read a byte; a high ninth bit marks the last byte of the read
  task automatic read_byte(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    rx_byte = d;
    rx_stb = 1'b1;
    tick(1);
    rx_stb = 1'b0;
    put_bit(last);
  endtask
endmodule // twowire_master_model
`default_nettype wire

// >>> verilog/key_latch_if.sv
// interface: key scan results from the key store to the bus engine
`timescale 1ns/1ns
`default_nettype none
interface key_latch_if;
  logic [7:0] rd_data;
  logic [2:0] rd_idx;
  logic clear_all;
  logic int_flag;
  modport store (input rd_idx, input clear_all, output rd_data, output int_flag);
  modport engine (output rd_idx, output clear_all, input rd_data, input int_flag);
endinterface
`default_nettype wire

// >>> verilog/key_store.sv
// key store: confirmed key presses, or-accumulated, cleared on read
`timescale 1ns/1ns
`default_nettype none
module key_store
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scan_done,
  input wire logic [38:0] scan_keys,
  key_latch_if.store kl
);
  logic [38:0] store_reg;
  logic [38:0] seen_reg;
  logic [38:0] conf_reg;
  logic int_reg;
  logic [38:0] fresh;
  // --------------------------------------------------------------
  // press detection
  // --------------------------------------------------------------
  // a key counts once it reads pressed in two back-to-back scans
  assign fresh = scan_keys & conf_reg & ~seen_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      conf_reg <= '0;
      seen_reg <= '0;
    end
    else if (scan_done)
    begin
      conf_reg <= scan_keys; // [R22]
      seen_reg <= (seen_reg | fresh) & scan_keys; // [R5]
    end
  end
  // store: new presses or-in, clear after the last byte is read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      store_reg <= '0;
      int_reg <= 1'b0;
    end
    else
    begin
      store_reg <= (kl.clear_all ? '0 : store_reg) | (scan_done ? fresh : '0); // [R1] [R2]
      if (scan_done && (|fresh))
        int_reg <= 1'b1; // [R22]
      else if (kl.clear_all)
        int_reg <= 1'b0; // [R4]
    end
  end
  // byte view: low byte keys 1-8, high byte keys 9-13 and zeros
  always_comb
  begin
    case (kl.rd_idx)
      3'h0: kl.rd_data = store_reg[7:0]; // [R9]
      3'h1: kl.rd_data = {3'h0, store_reg[12:8]};
      3'h2: kl.rd_data = store_reg[20:13];
      3'h3: kl.rd_data = {3'h0, store_reg[25:21]};
      3'h4: kl.rd_data = store_reg[33:26];
      3'h5: kl.rd_data = {3'h0, store_reg[38:34]};
      default: kl.rd_data = 8'h00;
    endcase
  end
  assign kl.int_flag = int_reg;
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_accum;
    @(posedge clk) disable iff (reset) !kl.clear_all |=> ((store_reg & $past(store_reg)) == $past(store_reg));
  endproperty
  a_accum: assert property (p_accum) else $error("key bit lost without read"); // [R2]
  property p_held_once;
    @(posedge clk) disable iff (reset) (scan_done && (|(seen_reg & scan_keys))) |-> ((fresh & seen_reg) == '0);
  endproperty
  a_held_once: assert property (p_held_once) else $error("held key reported again"); // [R5]
  property p_int_rise;
    @(posedge clk) disable iff (reset) $rose(int_reg) |-> $past(scan_done) && ($past(fresh) != '0);
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("flag rose without confirmed press"); // [R22]
  c_press: cover property (@(posedge clk) disable iff (reset) $rose(int_reg));
endmodule // key_store
`default_nettype wire

// >>> verilog/keyscan_i2c_slave.sv
// two-wire slave port serving the key store and command bytes
// How it works
// [R1] each stored bit marks a key pressed since the last store read
// [R2] a full read clears the store; unread presses or together
// [R3] no event queue; master reads all after each interrupt
// [R4] last key byte read drops interrupt pin and flag together; the pin here drops one clock after the flag
// [R5] held key reported and flagged once until released
// [R6] writes into key locations are discarded
// [R7] master should read all six key bytes from the first location
// [R8] scan lines map to byte pairs 40h-41h, 42h-43h, 44h-45h
// [R9] even byte keys 1-8, odd byte keys 9-13, top three bits zero
// [R10] start is data falling, stop data rising, both with clock high
// [R11] repeated start acts as start and expects a new address
// [R12] data changes only while clock is low
// [R13] eight bits msb first then one acknowledge slot, unlimited bytes
// [R14] slave pulls data low through the acknowledge clock high phase
// [R15] master nacks last read byte; slave then releases data
// [R16] first byte is seven address bits plus direction, 1 is read
// [R17] address must match 1110 plus three strap bits to acknowledge
// [R18] straps default low and are sampled at each frame start
// [R19] single write is address, command byte, data byte, stop
// [R20] write pointer advances per acknowledge, wraps 0fh to 00h
// [R21] master starts only on an idle bus
// [R22] presses update store and flag after two confirming scans
// [R23] interrupt pin active low when polarity bit is 0, else high
// [R24] key read pointer advances per acknowledge, wraps 45h to 40h
// [R25] single-byte key reads unsupported, only multi-byte sequence
// [R26] on address mismatch stay released until next start
`timescale 1ns/1ns
`default_nettype none
module keyscan_i2c_slave
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] addr_strap_bits,
  input wire logic scan_done,
  input wire logic [38:0] scan_keys,
  output logic int_out,
  output logic [7:0] disp_wr_addr,
  output logic [7:0] disp_wr_data,
  output logic disp_wr_stb
);
  typedef enum logic [2:0]
  {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_addr_ack = 3'b011,
    st_wr = 3'b010,
    st_wr_ack = 3'b110,
    st_rd = 3'b111,
    st_rd_ack = 3'b101,
    st_ignore = 3'b100
  } bus_state_e;
  bus_state_e state_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [2:0] strap_sync0_reg;
  logic [2:0] strap_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic byte_in_reg; // eight bits taken since the last start or byte
  logic [7:0] ptr_reg;
  logic first_wr_reg;
  logic read_dir_reg;
  logic [1:0] rowint_reg;
  logic [2:0] rd_bytes_reg;
  logic rd_from_key_reg;
  logic [7:0] tx_reg;
  logic clear_req;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_s;
  logic sda_s;
  key_latch_if kl ();
  key_store u_store
  (
    .clk(clk),
    .reset(reset),
    .scan_done(scan_done),
    .scan_keys(scan_keys),
    .kl(kl)
  );
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic is_key(input logic [7:0] a);
    is_key = (a >= keyscan_pkg::key_first) && (a <= keyscan_pkg::key_last);
  endfunction
  // advance pointer with wrap inside its own area
  function automatic logic [7:0] ptr_step(input logic [7:0] a);
    if (a == keyscan_pkg::disp_last)
      ptr_step = keyscan_pkg::disp_first; // [R20]
    else if (a == keyscan_pkg::key_last)
      ptr_step = keyscan_pkg::key_first; // [R24]
    else
      ptr_step = a + 8'h01;
  endfunction
  // --------------------------------------------------------------
  // pin synchronisers and line conditions
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // [R10] [R11]
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // [R10]
  // strap pins: synchronised, then caught at each frame start
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_sync0_reg <= 3'h0;
      strap_reg <= 3'h0;
    end
    else
    begin
      strap_sync0_reg <= addr_strap_bits;
      if (start_det)
        strap_reg <= strap_sync0_reg; // [R18]
    end
  end
  // --------------------------------------------------------------
  // bus state machine
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= st_idle;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_in_reg <= 1'b0;
      read_dir_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= st_addr; // [R11]
      bit_cnt_reg <= 3'h0;
      byte_in_reg <= 1'b0;
    end
    else if (stop_det)
      state_reg <= st_idle;
    else
    begin
      case (state_reg)
        st_idle, st_ignore: state_reg <= state_reg; // [R26]
        st_addr, st_wr:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s}; // [R13]
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_in_reg <= (bit_cnt_reg == 3'h7);
          end
          // the clock fall that ends a start must not be taken for a byte end
          if (scl_fall && bit_cnt_reg == 3'h0 && state_reg == st_addr && byte_in_reg)
          begin
            if (shift_reg[7:1] == {keyscan_pkg::addr_fixed, strap_reg}) // [R17]
            begin
              state_reg <= st_addr_ack;
              read_dir_reg <= shift_reg[0]; // [R16]
            end
            else
              state_reg <= st_ignore; // [R26]
          end
          else if (scl_fall && bit_cnt_reg == 3'h0 && state_reg == st_wr && byte_in_reg)
            state_reg <= st_wr_ack; // [R14]
        end
        st_addr_ack, st_wr_ack:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 3'h0;
            state_reg <= (state_reg == st_addr_ack && read_dir_reg) ? st_rd : st_wr;
          end
        end
        st_rd:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
              state_reg <= st_rd_ack;
          end
        end
        st_rd_ack:
        begin
          if (scl_rise)
            state_reg <= sda_s ? st_ignore : st_rd_ack; // [R15]
          if (scl_fall)
          begin
            bit_cnt_reg <= 3'h0;
            state_reg <= st_rd;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end
  // --------------------------------------------------------------
  // pointer, command decode and key read tracking
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ptr_reg <= keyscan_pkg::ptr_reset;
      first_wr_reg <= 1'b0;
      rowint_reg <= keyscan_pkg::rowint_reset;
      disp_wr_addr <= 8'h00;
      disp_wr_data <= 8'h00;
      disp_wr_stb <= 1'b0;
    end
    else
    begin
      disp_wr_stb <= 1'b0;
      if (state_reg == st_addr_ack && scl_fall)
        first_wr_reg <= ~read_dir_reg;
      if (state_reg == st_wr_ack && scl_fall)
      begin
        first_wr_reg <= 1'b0;
        if (first_wr_reg) // [R19]
        begin
          case (shift_reg[7:4])
            keyscan_pkg::cmd_disp_ptr: ptr_reg <= {4'h0, shift_reg[3:0]};
            keyscan_pkg::cmd_key_ptr: ptr_reg <= keyscan_pkg::key_first + {5'h00, shift_reg[2:0]};
            keyscan_pkg::cmd_int_ptr: ptr_reg <= keyscan_pkg::intflag_addr;
            keyscan_pkg::cmd_rowint: rowint_reg <= shift_reg[1:0];
            default: ptr_reg <= ptr_reg;
          endcase
        end
        else
        begin
          if (ptr_reg <= keyscan_pkg::disp_last)
          begin
            disp_wr_addr <= ptr_reg;
            disp_wr_data <= shift_reg;
            disp_wr_stb <= 1'b1;
          end
          // key locations take no data; pointer still moves
          ptr_reg <= ptr_step(ptr_reg); // [R6] [R20]
        end
      end
      if (state_reg == st_rd_ack && scl_rise && !sda_s)
        ptr_reg <= ptr_step(ptr_reg); // [R24]
    end
  end
  // count key bytes delivered in one read run; clear after all six
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_bytes_reg <= 3'h0;
      rd_from_key_reg <= 1'b0;
    end
    else if (state_reg == st_addr_ack && scl_fall)
    begin
      rd_bytes_reg <= 3'h0;
      rd_from_key_reg <= (ptr_reg == keyscan_pkg::key_first); // [R25] [R7]
    end
    else if (state_reg == st_rd && scl_fall && bit_cnt_reg == 3'h7 && rd_from_key_reg)
      rd_bytes_reg <= (rd_bytes_reg == keyscan_pkg::key_byte_idx_last) ? 3'h0 : rd_bytes_reg + 3'h1;
  end
  assign clear_req = state_reg == st_rd && scl_fall && bit_cnt_reg == 3'h7 && rd_from_key_reg
                     && rd_bytes_reg == keyscan_pkg::key_byte_idx_last;
  assign kl.clear_all = clear_req; // [R2] [R4]
  assign kl.rd_idx = is_key(ptr_reg) ? ptr_reg[2:0] : 3'h0; // [R8]
  // --------------------------------------------------------------
  // transmit byte and data line drive
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      tx_reg <= 8'h00;
    else if ((state_reg == st_addr_ack || state_reg == st_rd_ack) && scl_fall)
    begin
      if (is_key(ptr_reg))
        tx_reg <= kl.rd_data; // [R8] [R9]
      else if (ptr_reg == keyscan_pkg::intflag_addr)
        tx_reg <= {8{kl.int_flag}};
      else
        tx_reg <= 8'h00;
    end
    else if (state_reg == st_rd && scl_fall)
      tx_reg <= {tx_reg[6:0], 1'b0}; // [R13]
  end
  // drive only low, change once the clock is low, release at once on start or stop
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out <= 1'b0;
      if (scl_fall || start_det || stop_det) // [R12]
      begin
        if (start_det || stop_det)
          sda_oe_n <= 1'b1;
        else if ((state_reg == st_addr && bit_cnt_reg == 3'h0 && byte_in_reg
                  && shift_reg[7:1] == {keyscan_pkg::addr_fixed, strap_reg})
                 || (state_reg == st_wr && bit_cnt_reg == 3'h0 && byte_in_reg))
          sda_oe_n <= 1'b0; // [R14]
        else if (state_reg == st_addr_ack && read_dir_reg)
          sda_oe_n <= kl.rd_data[7] | ~is_key(ptr_reg);
        else if (state_reg == st_rd && bit_cnt_reg != 3'h7)
          sda_oe_n <= tx_reg[6];
        else if (state_reg == st_rd_ack)
          sda_oe_n <= kl.rd_data[7] | ~is_key(ptr_reg);
        else
          sda_oe_n <= 1'b1; // [R15] [R26]
      end
      else if (state_reg == st_ignore || state_reg == st_idle)
        sda_oe_n <= 1'b1;
    end
  end
  // --------------------------------------------------------------
  // interrupt pin
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      int_out <= 1'b1;
    else
      int_out <= kl.int_flag ~^ rowint_reg[keyscan_pkg::rowint_act_bit]; // [R23] [R4]
  end
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_int_pol;
    @(posedge clk) disable iff (reset) 1'b1 |=> int_out == ($past(kl.int_flag) ~^ $past(rowint_reg[1]));
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("interrupt pin polarity wrong"); // [R23]
  property p_clear;
    @(posedge clk) disable iff (reset) clear_req |=> !kl.int_flag || $past(scan_done);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared after full read"); // [R4]
  property p_sda_change;
    @(posedge clk) disable iff (reset) (scl_d_reg && scl_s && !start_det && !stop_det) |=> $stable(sda_oe_n);
  endproperty
  a_sda_change: assert property (p_sda_change) else $error("data moved with clock high"); // [R12]
  property p_ignore_quiet;
    @(posedge clk) disable iff (reset) state_reg == st_ignore |=> sda_oe_n;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("drove bus while unaddressed"); // [R26]
  property p_restart;
    @(posedge clk) disable iff (reset) start_det |=> state_reg == st_addr && bit_cnt_reg == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("start did not reopen address"); // [R11]
  property p_key_wrap;
    @(posedge clk) disable iff (reset) (state_reg == st_rd_ack && scl_rise && !sda_s && ptr_reg == 8'h45)
      |=> ptr_reg == 8'h40;
  endproperty
  a_key_wrap: assert property (p_key_wrap) else $error("key pointer did not wrap"); // [R24]
  property p_disp_wrap;
    @(posedge clk) disable iff (reset) (state_reg == st_wr_ack && scl_fall && !first_wr_reg && ptr_reg == 8'h0f)
      |=> ptr_reg == 8'h00;
  endproperty
  a_disp_wrap: assert property (p_disp_wrap) else $error("display pointer did not wrap"); // [R20]
  property p_key_no_write;
    @(posedge clk) disable iff (reset) disp_wr_stb |-> disp_wr_addr <= 8'h0f;
  endproperty
  a_key_no_write: assert property (p_key_no_write) else $error("write reached key area"); // [R6]
  c_match: cover property (@(posedge clk) disable iff (reset) state_reg == st_addr_ack);
  c_read: cover property (@(posedge clk) disable iff (reset) clear_req);
  c_write: cover property (@(posedge clk) disable iff (reset) disp_wr_stb);
endmodule // keyscan_i2c_slave
`default_nettype wire

// >>> verilog/keyscan_pkg.sv
// package: constants for the two-wire key store slave
`default_nettype none
package keyscan_pkg;
  // ---------------------------------------------------------------
  // key store map
  // ---------------------------------------------------------------
  localparam logic [7:0] key_line0_low_keys = 8'h40;
  localparam logic [7:0] key_line0_high_keys = 8'h41;
  localparam logic [7:0] key_line1_low_keys = 8'h42;
  localparam logic [7:0] key_line1_high_keys = 8'h43;
  localparam logic [7:0] key_line2_low_keys = 8'h44;
  localparam logic [7:0] key_line2_high_keys = 8'h45;
  localparam logic [7:0] key_first = key_line0_low_keys;
  localparam logic [7:0] key_last = key_line2_high_keys;
  localparam logic [7:0] disp_first = 8'h00;
  localparam logic [7:0] disp_last = 8'h0f;
  localparam logic [7:0] intflag_addr = 8'h60;
  // command groups, upper nibble of the first written byte
  localparam logic [3:0] cmd_disp_ptr = 4'h0;
  localparam logic [3:0] cmd_key_ptr = 4'h4;
  localparam logic [3:0] cmd_int_ptr = 4'h6;
  localparam logic [3:0] cmd_rowint = 4'ha;
  localparam int rowint_act_bit = 1;
  localparam int rowint_en_bit = 0;
  // ---------------------------------------------------------------
  // address and geometry
  // ---------------------------------------------------------------
  localparam logic [3:0] addr_fixed = 4'he;
  localparam int key_bits = 13;
  localparam int scan_lines = 3;
  localparam int key_bytes = 6;
  localparam logic [2:0] key_byte_idx_last = 3'h5;
  localparam logic [1:0] confirm_scans = 2'h2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ptr_reset = 8'h40;
  localparam logic [1:0] rowint_reset = 2'h0;
endpackage
`default_nettype wire
